// ===== logic/sadc_top.sv
// Converter control top: APB registers, conversion sequencing and result storage.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_top import sadc_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_above,
    output logic [9:0] tap_code,
    output logic sample_hold,
    output logic comparator_power,
    output logic conv_clk_en,
    output logic [7:0] analog_route,
    output logic [2:0] input_channel_select,
    output logic conversion_end_irq
);

    // ****************************************************************
    // State and submodules
    // ****************************************************************

    sadc_top_t q;
    sadc_top_t d;

    logic step;
    logic sar_done;
    logic [9:0] sar_code;
    logic [3:0] sar_idx;
    logic [9:0] resolved;
    logic conv_on;
    logic access;
    logic wr_now;
    logic mapped;
    logic [3:0] stop_idx;

    assign conv_on = q.per_en[`SADC_CONV_EN_BIT];
    assign stop_idx = q.res8 ? `SADC_STOP_EIGHT : `SADC_STOP_TEN;

    sadc_div u_div (
        .clk(clk),
        .reset_n(reset_n),
        .run(conv_on && (q.st != SADC_IDLE)),
        .step(step)
    );

    // The register is reloaded with the MSB trial whenever no bit search runs.
    sadc_sar u_sar (
        .clk(clk),
        .reset_n(reset_n),
        .clear(q.st != SADC_CONVERT),
        .step(step && (q.st == SADC_CONVERT)),
        .stop_idx(stop_idx),
        .cmp_above(cmp_above),
        .sar_code(sar_code),
        .sar_idx(sar_idx),
        .resolved(resolved),
        .done(sar_done)
    );

    // ****************************************************************
    // Bus decode
    // ****************************************************************

    // One wait state: pready rises in the second access cycle and the write lands there.
    assign access = psel && penable;
    assign wr_now = access && q.pready && pwrite && !q.pslverr && pstrb[0];

    always_comb begin
        mapped = 1'b0;
        unique case (paddr)
            `SADC_PER_EN_ADDR,
            `SADC_MODE0_ADDR,
            `SADC_MODE2_ADDR,
            `SADC_RES_HI_ADDR,
            `SADC_RES_LO_ADDR,
            `SADC_CHAN_ADDR: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************

    always_comb begin
        d = q;
        d.irq = 1'b0;
        d.pready = access && !q.pready;
        d.pslverr = access && !q.pready && !mapped;

        if (access && !q.pready) begin
            unique case (paddr)
                `SADC_PER_EN_ADDR: begin
                    d.prdata = q.per_en;
                end
                `SADC_MODE0_ADDR: begin
                    d.prdata = {q.start, 6'h00, q.cmp_en};
                end
                `SADC_MODE2_ADDR: begin
                    d.prdata = {7'h00, q.res8};
                end
                `SADC_RES_HI_ADDR: begin
                    d.prdata = q.res_hi;
                end
                `SADC_RES_LO_ADDR: begin
                    d.prdata = {q.res_lo, 6'h00};
                end
                `SADC_CHAN_ADDR: begin
                    d.prdata = {5'h00, q.chan};
                end
                default: begin
                    d.prdata = 8'h00;
                end
            endcase
        end

        // Unused enable positions are not stored, so a stray one reads back as zero.
        if (wr_now && (paddr == `SADC_PER_EN_ADDR)) begin
            d.per_en = pwdata[7:0] & `SADC_PER_WMASK;
        end

        // ************************************************************
        // Conversion sequencing
        // ************************************************************

        unique case (q.st)
            SADC_IDLE: begin
                d.hold = 1'b0;
                if (q.start) begin
                    d.st = SADC_SAMPLE;
                    d.samp_cnt = `SADC_SAMPLE_STEPS;
                end
            end
            SADC_SAMPLE: begin
                d.hold = 1'b0;
                if (step) begin
                    d.samp_cnt = q.samp_cnt - 4'h1;
                    if (q.samp_cnt == 4'h1) begin
                        d.st = SADC_CONVERT;
                        d.hold = 1'b1;
                    end
                end
            end
            SADC_CONVERT: begin
                d.hold = 1'b1;
                if (sar_done) begin
                    d.res_hi = resolved[9:2];
                    d.res_lo = resolved[1:0];
                    d.irq = 1'b1;
                    d.start = 1'b0;
                    d.st = SADC_IDLE;
                    d.hold = 1'b0;
                end
            end
        endcase

        if (wr_now && conv_on) begin
            unique case (paddr)
                `SADC_MODE0_ADDR: begin
                    d.cmp_en = pwdata[`SADC_CMP_EN_BIT];
                    if (!pwdata[`SADC_START_BIT]) begin
                        d.start = 1'b0;
                    end else if (q.cmp_en && pwdata[`SADC_CMP_EN_BIT] && !q.start) begin
                        d.start = 1'b1;
                    end
                end
                `SADC_MODE2_ADDR: begin
                    d.res8 = pwdata[`SADC_RES_SEL_BIT];
                end
                `SADC_CHAN_ADDR: begin
                    d.chan = pwdata[2:0];
                end
                default: begin
                end
            endcase
        end

        // Clearing the start bit stops a conversion without touching the result.
        if (!d.start && (q.st != SADC_IDLE) && !sar_done) begin
            d.st = SADC_IDLE;
            d.hold = 1'b0;
        end

        // Only the selected input reaches the converter; the rest stay port pins.
        d.route = (conv_on && d.cmp_en) ? (8'h01 << d.chan) : 8'h00;

        // With the clock enable off the converter sits in reset and ignores writes.
        if (!d.per_en[`SADC_CONV_EN_BIT]) begin
            d.start = 1'b0;
            d.cmp_en = 1'b0;
            d.res8 = 1'b0;
            d.chan = 3'h0;
            d.res_hi = 8'h00;
            d.res_lo = 2'h0;
            d.st = SADC_IDLE;
            d.samp_cnt = 4'h0;
            d.hold = 1'b0;
            d.irq = 1'b0;
            d.route = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
            q.per_en <= `SADC_PER_RESET;
            q.st <= SADC_IDLE;
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign prdata = {24'h000000, q.prdata};
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign tap_code = sar_code;
    assign sample_hold = q.hold;
    assign comparator_power = q.cmp_en;
    assign conv_clk_en = q.per_en[`SADC_CONV_EN_BIT];
    assign analog_route = q.route;
    assign input_channel_select = q.chan;
    assign conversion_end_irq = q.irq;

    // ****************************************************************
    // Checks
    // ****************************************************************

    chk_msb_first: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(q.hold) |-> (tap_code == 10'h200))
        else $error("first trial is not the half-reference code");

    chk_second_tap: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st == SADC_CONVERT && step && sar_idx == 4'h9 && !sar_done)
        |=> (tap_code[8] && tap_code[9] == $past(cmp_above) && tap_code[7:0] == 8'h00))
        else $error("second trial tap not derived from decided msb");

    chk_bit_decide: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st == SADC_CONVERT && step && sar_idx == 4'h5)
        |=> (tap_code[5] == $past(cmp_above) && tap_code[4] && tap_code[3:0] == 4'h0))
        else $error("trial bit five not decided by the comparator");

    chk_ten_bit_end: assert property (@(posedge clk) disable iff (!reset_n)
        (sar_done && !q.res8) |-> (sar_idx == 4'h0))
        else $error("ten-bit search ended before bit zero");

    chk_eight_bit_end: assert property (@(posedge clk) disable iff (!reset_n)
        (sar_done && q.res8) |-> (sar_idx == 4'h2) ##1 (q.res_lo == 2'h0))
        else $error("eight-bit search did not stop at bit two");

    chk_result_copy: assert property (@(posedge clk) disable iff (!reset_n)
        sar_done |=> (q.res_hi == $past(resolved[9:2]) && q.res_lo == $past(resolved[1:0])))
        else $error("result registers not loaded from the finished search");

    chk_irq_done: assert property (@(posedge clk) disable iff (!reset_n)
        conversion_end_irq |-> ($past(sar_done) && !$past(conversion_end_irq)))
        else $error("interrupt pulse without a finished conversion");

    chk_hold_conv: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st == SADC_CONVERT) |-> (sample_hold && $stable(tap_code[9]) || step || $past(step)))
        else $error("sample-and-hold released during bit decisions");

    chk_gate_reset: assert property (@(posedge clk) disable iff (!reset_n)
        !conv_clk_en |-> (!q.start && q.res_hi == 8'h00 && !comparator_power && !sample_hold))
        else $error("converter state alive while its clock is gated");

    chk_start_clear: assert property (@(posedge clk) disable iff (!reset_n)
        (sar_done && q.st == SADC_CONVERT) |=> (!q.start && q.st == SADC_IDLE))
        else $error("start bit not cleared at conversion end");

    chk_start_needs_cmp: assert property (@(posedge clk) disable iff (!reset_n)
        q.start |-> comparator_power)
        else $error("start bit set with comparator disabled");

    chk_step_spacing: assert property (@(posedge clk) disable iff (!reset_n)
        step |=> !step [*3])
        else $error("conversion steps closer than the step period");

    chk_ready_pulse: assert property (@(posedge clk) disable iff (!reset_n)
        pready |=> !pready)
        else $error("pready held longer than one cycle");

    chk_err_ready: assert property (@(posedge clk) disable iff (!reset_n)
        pslverr |-> pready)
        else $error("pslverr raised outside the answer cycle");

    chk_gate_idle: assert property (@(posedge clk) disable iff (!reset_n)
        !conv_clk_en |-> (analog_route == 8'h00 && !conversion_end_irq && q.st == SADC_IDLE))
        else $error("converter active while its clock is gated");

    chk_route_sel: assert property (@(posedge clk) disable iff (!reset_n)
        (analog_route != 8'h00)
        |-> (analog_route == (8'h01 << input_channel_select) && comparator_power))
        else $error("analog route does not match the selected channel");

    chk_hi_read: assert property (@(posedge clk) disable iff (!reset_n)
        (pready && !pwrite && paddr == `SADC_RES_HI_ADDR)
        |-> (prdata[7:0] == $past(q.res_hi)))
        else $error("high result read does not return the stored byte");

    chk_lo_read: assert property (@(posedge clk) disable iff (!reset_n)
        (pready && !pwrite && paddr == `SADC_RES_LO_ADDR)
        |-> (prdata[7:0] == {$past(q.res_lo), 6'h00}))
        else $error("low result read does not return two bits over zeros");

    chk_per_reset: assert property (@(posedge clk) disable iff (!reset_n)
        !$past(reset_n) |-> (q.per_en == `SADC_PER_RESET))
        else $error("peripheral enable not zero after reset");

    chk_per_unused: assert property (@(posedge clk) disable iff (!reset_n)
        (q.per_en & ~(`SADC_PER_WMASK)) == 8'h00)
        else $error("unused peripheral enable position stored a one");

    chk_hold_on_step: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(sample_hold) |-> $past(step))
        else $error("hold began without a conversion-clock step");

    chk_start_sample: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st == SADC_IDLE && q.start) |=> (q.st == SADC_SAMPLE || !conv_clk_en))
        else $error("set start bit did not begin sampling");

    chk_tap_reload: assert property (@(posedge clk) disable iff (!reset_n)
        ($past(reset_n) && q.st != SADC_CONVERT && $past(q.st) != SADC_CONVERT)
        |-> (tap_code == `SADC_MSB_TRIAL))
        else $error("tap not reloaded with the half-reference trial");

    chk_run_start: assert property (@(posedge clk) disable iff (!reset_n)
        (q.st != SADC_IDLE) |-> q.start)
        else $error("conversion runs with the start bit clear");

endmodule

// ===== logic/sadc_map.svh
// Register map, field positions, reset values and timing counts of the converter control.
//
// Operation
// - First trial decides MSB against half reference
// - After MSB, next lower bit set as trial
// - Second tap follows decided MSB: quarter/three-quarter
// - Trial bit kept when input at/above tap
// - Ten-bit search runs down to bit zero
// - Eight-bit search stops after bit two
// - Finished value copied into held result registers
// - Conversion end raises interrupt request pulse
// - High result register holds upper eight bits
// - Low register: two LSBs on top, rest zero
// - Sample-and-hold holds during bit decisions
// - Clock and register access need enable bit five
// - Enable zero keeps converter registers in reset
// - Peripheral enable register resets to zero
// - Peripheral enable accepts bit and byte writes
// - Controller governs timing, start and stop
// - Only the selected analog pin is routed
// - Resolution bit: zero ten-bit, one eight-bit
// - Start bit self-clears at end, or on zero
// - Start write ignored while comparator disabled
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH

`define SADC_PER_EN_ADDR 20'hf00f0
`define SADC_MODE0_ADDR 20'hfff30
`define SADC_MODE2_ADDR 20'hf0010
`define SADC_RES_HI_ADDR 20'hfff1c
`define SADC_RES_LO_ADDR 20'hfff18
`define SADC_CHAN_ADDR 20'hfff34

`define SADC_CONV_EN_BIT 5
`define SADC_START_BIT 7
`define SADC_CMP_EN_BIT 0
`define SADC_RES_SEL_BIT 0
`define SADC_PER_RESET 8'h00
`define SADC_PER_WMASK 8'he5

`define SADC_CLK_NS 20
`define SADC_STEP_NS 80
`define SADC_STEP_CYCLES ((`SADC_STEP_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_SAMPLE_STEPS 4'h9
`define SADC_MSB_IDX 4'h9
`define SADC_STOP_TEN 4'h0
`define SADC_STOP_EIGHT 4'h2
`define SADC_MSB_TRIAL 10'h200

`endif

// ===== logic/sadc_pkg.sv
// Types shared by the converter control modules.
package sadc_pkg;

    typedef enum logic [2:0] {
        SADC_IDLE = 3'b001,
        SADC_SAMPLE = 3'b010,
        SADC_CONVERT = 3'b100
    } sadc_state_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic step;
    } sadc_div_t;

    typedef struct packed {
        logic [9:0] sar;
        logic [3:0] idx;
    } sadc_sar_t;

    typedef struct packed {
        logic [7:0] per_en;
        logic start;
        logic cmp_en;
        logic res8;
        logic [2:0] chan;
        logic [7:0] res_hi;
        logic [1:0] res_lo;
        sadc_state_t st;
        logic [3:0] samp_cnt;
        logic hold;
        logic irq;
        logic [7:0] route;
        logic pready;
        logic pslverr;
        logic [7:0] prdata;
    } sadc_top_t;

endpackage

// ===== logic/sadc_div.sv
// Conversion-clock step generator.
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_div import sadc_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    output logic step
);
    localparam logic [2:0] LAST = 3'(`SADC_STEP_CYCLES - 1);

    sadc_div_t q;
    sadc_div_t d;

    always_comb begin
        d = q;
        d.step = 1'b0;
        if (!run) begin
            d.cnt = 3'h0;
        end else if (q.cnt == LAST) begin
            d.cnt = 3'h0;
            d.step = 1'b1;
        end else begin
            d.cnt = q.cnt + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign step = q.step;
endmodule

// ===== logic/sadc_sar.sv
// Successive approximation register with one decided bit per step.
`timescale 1ns/1ps
`include "sadc_map.svh"
module sadc_sar import sadc_pkg::*; (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clear,
    input wire logic step,
    input wire logic [3:0] stop_idx,
    input wire logic cmp_above,
    output logic [9:0] sar_code,
    output logic [3:0] sar_idx,
    output logic [9:0] resolved,
    output logic done
);
    sadc_sar_t q;
    sadc_sar_t d;
    logic [9:0] cur_bit;
    logic [9:0] next_bit;

    genvar i;
    generate
        for (i = 0; i < 10; i++) begin : g_bit
            assign cur_bit[i] = (q.idx == 4'(i));
            assign next_bit[i] = (q.idx == 4'(i + 1));
        end
    endgenerate

    // The trial bit stays only when the held input is at or above the tap.
    assign resolved = cmp_above ? q.sar : (q.sar & ~cur_bit);
    assign done = step && (q.idx == stop_idx);

    always_comb begin
        d = q;
        if (clear) begin
            d.sar = `SADC_MSB_TRIAL;
            d.idx = `SADC_MSB_IDX;
        end else if (step && !done) begin
            // The next tap is built from the bits already decided above it.
            d.sar = resolved | next_bit;
            d.idx = q.idx - 4'h1;
        end else if (done) begin
            d.sar = resolved;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sar_code = q.sar;
    assign sar_idx = q.idx;
endmodule

// ===== test/sadc_analog_model.sv
// Behavioural analog front end: sample-and-hold, tap generator and comparator.
`timescale 1ns/1ps
module sadc_analog_model (
    input wire logic clk,
    input wire logic [9:0] vin,
    input wire logic [9:0] tap_code,
    input wire logic sample_hold,
    input wire logic comparator_power,
    output logic cmp_above
);
    logic [9:0] held_q;
    logic junk_q;

    initial begin
        junk_q = 1'b0;
        held_q = 10'h000;
    end

    always @(posedge clk) begin
        junk_q <= ~junk_q;
        if (sample_hold !== 1'b1) begin
            held_q <= vin;
        end
    end

    // A tracking or unpowered comparator has no valid answer, so it toggles every cycle.
    assign cmp_above = (sample_hold && comparator_power) ? (held_q >= tap_code) : junk_q;
endmodule

// ===== test/sadc_top_test.sv
// Self-checking testbench of the converter control top.
`timescale 1ns/1ps
`include "sadc_map.svh"
`define CHK(nm, e, g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        fail_count++; \
        $display("BAD %s exp %h got %h", nm, e, g); \
    end \
end
module sadc_top_test import sadc_pkg::*; ;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [19:0] paddr = 20'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'h0;
    logic [9:0] vin = 10'h000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmp_above;
    logic [9:0] tap_code;
    logic sample_hold;
    logic comparator_power;
    logic conv_clk_en;
    logic [7:0] analog_route;
    logic [2:0] input_channel_select;
    logic conversion_end_irq;
    int fail_count = 0;
    int n_checks = 0;

    always #10 clk = ~clk;

    sadc_top dut_u (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_above(cmp_above), .tap_code(tap_code),
        .sample_hold(sample_hold), .comparator_power(comparator_power),
        .conv_clk_en(conv_clk_en), .analog_route(analog_route),
        .input_channel_select(input_channel_select), .conversion_end_irq(conversion_end_irq));

    sadc_analog_model model_u (.clk(clk), .vin(vin), .tap_code(tap_code),
        .sample_hold(sample_hold), .comparator_power(comparator_power), .cmp_above(cmp_above));

    // ****************************************
    // Bus and wait tasks.
    // ****************************************
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Entered just after a rising edge; returns one idle edge after pready was sampled.
    task apb(input logic wr, input logic [19:0] a, input logic [7:0] d,
             output logic [7:0] rd, output logic err);
        int i;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= 4'h1;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            fail_count++;
            $display("BAD apb_ready exp 1 got timeout");
            wrap_up();
        end
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // The idle edge keeps the next call from changing a strobe twice in one step.
        @(posedge clk);
    endtask

    task wr8(input logic [19:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task rdchk(input string nm, input logic [19:0] a, input logic [7:0] exp);
        logic [7:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        `CHK(nm, exp, r)
    endtask

    task wait_for(input bit irq);
        int i;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if ((irq ? conversion_end_irq : sample_hold) === 1'b1) break;
        end
        if (i == 200) begin
            fail_count++;
            $display("BAD wait exp 1 got timeout");
            wrap_up();
        end
    endtask

    // ****************************************
    // Scenarios.
    // ****************************************
    task conv(input logic [9:0] v, input logic eight);
        logic [9:0] e;
        e = eight ? {v[9:2], 2'b00} : v;
        vin <= v;
        wr8(`SADC_MODE2_ADDR, {7'h00, eight});
        wr8(`SADC_MODE0_ADDR, 8'h01);
        wr8(`SADC_MODE0_ADDR, 8'h81);
        wait_for(1'b0);
        `CHK("first_tap", 10'h200, tap_code)
        wait_for(1'b1);
        rdchk("result_high", `SADC_RES_HI_ADDR, e[9:2]);
        rdchk("result_low", `SADC_RES_LO_ADDR, {e[1:0], 6'h00});
        rdchk("start_cleared", `SADC_MODE0_ADDR, 8'h01);
    endtask

    initial begin
        logic [9:0] vals[5];
        logic [7:0] r;
        logic e;
        int k;
        vals = '{10'h000, 10'h3ff, 10'h200, 10'h1ff, 10'h2b7};
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdchk("per_reset", `SADC_PER_EN_ADDR, 8'h00);
        wr8(`SADC_MODE2_ADDR, 8'h01);
        rdchk("mode2_gated", `SADC_MODE2_ADDR, 8'h00);
        `CHK("clk_en_off", 1'b0, conv_clk_en)
        // Unused enable bits are written as zero, as software must.
        wr8(`SADC_PER_EN_ADDR, 8'he5);
        rdchk("per_rw", `SADC_PER_EN_ADDR, 8'he5);
        `CHK("clk_en_on", 1'b1, conv_clk_en)
        apb(1'b0, 20'hfff00, 8'h00, r, e);
        `CHK("unmapped_err", 1'b1, e)
        wr8(`SADC_MODE0_ADDR, 8'h80);
        rdchk("start_refused", `SADC_MODE0_ADDR, 8'h00);
        wr8(`SADC_CHAN_ADDR, 8'h03);
        wr8(`SADC_MODE0_ADDR, 8'h01);
        @(posedge clk);
        `CHK("route", 8'h08, analog_route)
        `CHK("cmp_power_on", 1'b1, comparator_power)
        `CHK("chan_out", 3'h3, input_channel_select)
        rdchk("chan_rd", `SADC_CHAN_ADDR, 8'h03);
        foreach (vals[i]) conv(vals[i], 1'b0);
        conv(10'h2b7, 1'b1);
        conv(10'h1ff, 1'b1);
        // Abort in mid-search: no completion may follow and the held result must survive.
        wr8(`SADC_MODE0_ADDR, 8'h81);
        wait_for(1'b0);
        repeat (8) @(posedge clk);
        wr8(`SADC_MODE0_ADDR, 8'h01);
        for (k = 0; k < 100; k++) begin
            @(posedge clk);
            if (conversion_end_irq === 1'b1) break;
        end
        `CHK("abort_no_irq", 100, k)
        `CHK("abort_hold", 1'b0, sample_hold)
        rdchk("result_kept", `SADC_RES_HI_ADDR, 8'h7f);
        wr8(`SADC_PER_EN_ADDR, 8'h00);
        wr8(`SADC_PER_EN_ADDR, 8'he5);
        rdchk("result_cleared", `SADC_RES_HI_ADDR, 8'h00);
        rdchk("mode0_cleared", `SADC_MODE0_ADDR, 8'h00);
        `CHK("cmp_power_off", 1'b0, comparator_power)
        wrap_up();
    end
endmodule
